// ---- design/async_serial_transmitter.v ----
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "serial_tx_map.vh"

// Behaviour
// - line held high while enabled and nothing is sent
// - output enable released when transmitter and receiver both disabled
// - word length eight bits, or nine when word length select set
// - start bit drives line low for one bit period
// - stop bit drives line high
// - data shifted out least significant bit first
// - ninth bit taken from tx_ninth_bit in nine-bit mode, or the parity bit when parity enabled
// - idle frame is a whole frame of ones before next frame
// - break is zero frames followed by one extra high bit
// - enabling transmitter sends an idle frame before first data, except a word held while disabled: that word goes first, the idle frame follows it
// - buffer empty flag cleared only by status access then data write
// - interrupt raised when buffer empty and its enable set, mask clear
// - write during transmission held and loaded at frame end
// - write while idle loads shifter, starts, sets buffer empty at once
// - complete flag set after stop bit or break frame, may interrupt
// - separate transmit and receive bit-rate generators, rate limited
// - complete flag cleared by same status-then-data sequence
// - break frames repeat while break bit set, then one high bit
// - enable toggled mid-frame sends idle after word, held data lost
module async_serial_transmitter (
	// clock and reset
	input  wire                clk_sys,
	input  wire                reset_n,
	// apb slave
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr,
	// cpu side
	input  wire                irq_global_mask,
	output reg                 irq_request,
	// serial pins
	input  wire                serial_rx_in,
	output reg                 serial_tx_out,
	output reg                 serial_tx_oe,
	// receive bit timing for the receiver path
	output reg                 rx_bit_tick
);

	// ==========================================================
	// states
	localparam [2:0] ST_IDLE      = 3'h0;
	localparam [2:0] ST_PREAMBLE  = 3'h1;
	localparam [2:0] ST_START     = 3'h2;
	localparam [2:0] ST_DATA      = 3'h3;
	localparam [2:0] ST_STOP      = 3'h4;
	localparam [2:0] ST_BREAK     = 3'h5;
	localparam [2:0] ST_BREAK_END = 3'h6;

	// the floor is worked out in 32 bits, then cut to the divisor width on purpose
	localparam integer      DIV_MIN_FULL = `BAUD_DIV_MIN;
	localparam [`DIV_W-1:0] DIV_MIN      = DIV_MIN_FULL[`DIV_W-1:0];

	// ==========================================================
	// state
	reg [2:0]           state_reg;
	reg [2:0]           state_next;
	reg [`CNT_W-1:0]    cnt_reg;
	reg [`CNT_W-1:0]    cnt_next;
	reg [`WORD_W-1:0]   shift_reg;
	reg [`WORD_W-1:0]   shift_next;
	reg [`DATA_W-1:0]   hold_reg;
	reg [`DATA_W-1:0]   hold_next;
	reg                 hold_full_reg;
	reg                 hold_full_next;
	reg                 idle_pend_reg;
	reg                 idle_pend_next;
	reg                 tx_buffer_empty_flag_reg;
	reg                 tx_buffer_empty_flag_next;
	reg                 tc_reg;
	reg                 tc_next;
	reg                 armed_reg;
	reg                 armed_next;
	reg                 line_next;
	reg                 tx_en_d_reg;
	reg [`C1_W-1:0]     ctrl_one_reg;
	reg [`C2_W-1:0]     ctrl_two_reg;
	reg [`DIV_W-1:0]    tx_div_reg;
	reg [`DIV_W-1:0]    rx_div_reg;
	reg                 boundary;
	reg                 frame_end;
	reg                 load_word;
	reg [`DATA_W-1:0]   load_src;
	reg [`WORD_W-1:0]   load_val;
	reg                 parity;
	reg [31:0]          rdata_next;
	reg                 err_next;

	wire                tx_tick;
	wire                rx_tick;
	wire                rx_line;

	wire word9     = ctrl_one_reg[`C1_WORD9];
	wire ninth     = ctrl_one_reg[`C1_NINTH];
	wire par_en    = ctrl_one_reg[`C1_PAR_EN];
	wire par_odd   = ctrl_one_reg[`C1_PAR_ODD];
	wire tx_en     = ctrl_two_reg[`C2_TX_EN];
	wire rx_en     = ctrl_two_reg[`C2_RX_EN];
	wire brk       = ctrl_two_reg[`C2_BREAK];
	wire tx_empty_irq_enable       = ctrl_two_reg[`C2_TIE];
	wire tx_complete_irq_enable      = ctrl_two_reg[`C2_TX_COMPLETE_IRQ_ENABLE];

	wire [`CNT_W-1:0] nbits     = word9 ? `BITS_9 : `BITS_8;
	wire [`CNT_W-1:0] frame_len = nbits + `FRAME_EXTRA;

	// ==========================================================
	// apb decode
	wire apb_setup = psel & ~penable;
	wire apb_done  = psel & penable & pready;
	wire wr_done   = apb_done & pwrite;
	wire data_wr   = wr_done & (paddr == `ADDR_DATA);
	wire stat_acc  = apb_done & (paddr == `ADDR_STATUS);
	wire en_rise   = tx_en & ~tx_en_d_reg;

	// ==========================================================
	// bit-rate generators
	baud_gen u_tx_baud (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.run     (state_reg != ST_IDLE),
		.divisor (tx_div_reg),
		.tick    (tx_tick)
	);

	baud_gen u_rx_baud (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.run     (rx_en),
		.divisor (rx_div_reg),
		.tick    (rx_tick)
	);

	sync_two_ff u_rx_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.din     (serial_rx_in),
		.dout    (rx_line)
	);

	// ==========================================================
	// word build
	always @* begin
		load_src = hold_full_reg ? hold_reg : pwdata[`DATA_W-1:0];
		if (word9) begin
			parity   = (^load_src) ^ par_odd;
			load_val = {ninth, load_src};
			if (par_en) begin
				load_val[`WORD_W-1] = parity;
			end
		end else begin
			parity   = (^load_src[`DATA_W-2:0]) ^ par_odd;
			load_val = {1'b0, load_src};
			if (par_en) begin
				load_val[`DATA_W-1] = parity;
			end
		end
	end

	// ==========================================================
	// frame sequencer
	always @* begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		shift_next     = shift_reg;
		hold_next      = hold_reg;
		hold_full_next = hold_full_reg;
		idle_pend_next = idle_pend_reg;
		tx_buffer_empty_flag_next      = tx_buffer_empty_flag_reg;
		tc_next        = tc_reg;
		armed_next     = armed_reg;
		line_next      = serial_tx_out;
		boundary       = 1'b0;
		frame_end      = 1'b0;
		load_word      = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				line_next = 1'b1;
				boundary  = tx_en;
			end
			ST_PREAMBLE: begin
				if (tx_tick) begin
					if (cnt_reg == {`CNT_W{1'b0}}) begin
						boundary = 1'b1;
					end else begin
						cnt_next = cnt_reg - {{(`CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_START: begin
				if (tx_tick) begin
					state_next = ST_DATA;
					cnt_next   = nbits - {{(`CNT_W-1){1'b0}}, 1'b1};
					line_next  = shift_reg[0];
				end
			end
			ST_DATA: begin
				if (tx_tick) begin
					if (cnt_reg == {`CNT_W{1'b0}}) begin
						state_next = ST_STOP;
						line_next  = 1'b1;
					end else begin
						shift_next = {1'b0, shift_reg[`WORD_W-1:1]};
						line_next  = shift_reg[1];
						cnt_next   = cnt_reg - {{(`CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_STOP: begin
				if (tx_tick) begin
					frame_end = 1'b1;
					boundary  = 1'b1;
				end
			end
			ST_BREAK: begin
				if (tx_tick) begin
					if (cnt_reg == {`CNT_W{1'b0}}) begin
						frame_end = 1'b1;
						if (brk) begin
							cnt_next = frame_len - {{(`CNT_W-1){1'b0}}, 1'b1};
						end else begin
							state_next = ST_BREAK_END;
							line_next  = 1'b1;
						end
					end else begin
						cnt_next = cnt_reg - {{(`CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_BREAK_END: begin
				if (tx_tick) begin
					boundary = 1'b1;
				end
			end
			default: begin
				state_next = ST_IDLE;
				line_next  = 1'b1;
			end
		endcase

		// what follows a finished frame, or starts from idle
		if (boundary) begin
			if (!tx_en) begin
				state_next = ST_IDLE;
				line_next  = 1'b1;
			end else if (idle_pend_reg) begin
				state_next     = ST_PREAMBLE;
				cnt_next       = frame_len - {{(`CNT_W-1){1'b0}}, 1'b1};
				line_next      = 1'b1;
				idle_pend_next = 1'b0;
			end else if (brk) begin
				state_next = ST_BREAK;
				cnt_next   = frame_len - {{(`CNT_W-1){1'b0}}, 1'b1};
				line_next  = 1'b0;
			end else if (hold_full_reg || data_wr) begin
				load_word  = 1'b1;
				state_next = ST_START;
				shift_next = load_val;
				line_next  = 1'b0;
			end else begin
				state_next = ST_IDLE;
				line_next  = 1'b1;
			end
		end

		// status access arms the clear, the data write fires it
		if (stat_acc) begin
			armed_next = 1'b1;
		end
		if (data_wr) begin
			armed_next = 1'b0;
			if (armed_reg) begin
				tx_buffer_empty_flag_next = 1'b0;
				tc_next   = 1'b0;
			end
		end

		// sets come after the clears so a same-cycle event wins
		if (load_word) begin
			hold_full_next = 1'b0;
			tx_buffer_empty_flag_next      = 1'b1;
		end
		if (frame_end) begin
			tc_next = 1'b1;
		end
		if (data_wr && !(load_word && !hold_full_reg)) begin
			hold_next      = pwdata[`DATA_W-1:0];
			hold_full_next = 1'b1;
		end

		// re-enable drops the held word only when not in ST_IDLE
		if (en_rise) begin
			idle_pend_next = 1'b1;
			if (state_reg != ST_IDLE) begin
				hold_full_next = 1'b0;
			end
		end
	end

	// ==========================================================
	// apb read mux and error
	always @* begin
		rdata_next = 32'h0000_0000;
		err_next   = 1'b0;
		case (paddr)
			`ADDR_STATUS: begin
				rdata_next[`ST_TX_BUFFER_EMPTY_FLAG]    = tx_buffer_empty_flag_reg;
				rdata_next[`ST_TC]      = tc_reg;
				rdata_next[`ST_BUSY]    = (state_reg != ST_IDLE);
				rdata_next[`ST_RX_LINE] = rx_line;
			end
			`ADDR_DATA: begin
				rdata_next = 32'h0000_0000;
			end
			`ADDR_CTRL_ONE: begin
				rdata_next[`C1_W-1:0] = ctrl_one_reg;
			end
			`ADDR_CTRL_TWO: begin
				rdata_next[`C2_W-1:0] = ctrl_two_reg;
			end
			`ADDR_TX_DIV: begin
				rdata_next[`DIV_W-1:0] = tx_div_reg;
			end
			`ADDR_RX_DIV: begin
				rdata_next[`DIV_W-1:0] = rx_div_reg;
			end
			default: begin
				err_next = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// registers
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= {`CNT_W{1'b0}};
			shift_reg     <= {`WORD_W{1'b0}};
			hold_reg      <= {`DATA_W{1'b0}};
			hold_full_reg <= 1'b0;
			idle_pend_reg <= 1'b0;
			tx_buffer_empty_flag_reg      <= `TX_BUFFER_EMPTY_FLAG_RST;
			tc_reg        <= `TC_RST;
			armed_reg     <= 1'b0;
			tx_en_d_reg   <= 1'b0;
			ctrl_one_reg  <= `CTRL_ONE_RST;
			ctrl_two_reg  <= `CTRL_TWO_RST;
			tx_div_reg    <= `DIV_RST;
			rx_div_reg    <= `DIV_RST;
			prdata        <= 32'h0000_0000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			irq_request   <= 1'b0;
			serial_tx_out <= 1'b1;
			serial_tx_oe  <= 1'b0;
			rx_bit_tick   <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			shift_reg     <= shift_next;
			hold_reg      <= hold_next;
			hold_full_reg <= hold_full_next;
			idle_pend_reg <= idle_pend_next;
			tx_buffer_empty_flag_reg      <= tx_buffer_empty_flag_next;
			tc_reg        <= tc_next;
			armed_reg     <= armed_next;
			tx_en_d_reg   <= tx_en;
			serial_tx_out <= line_next;
			serial_tx_oe  <= tx_en | rx_en;
			rx_bit_tick   <= rx_tick;
			// mask comes from the cpu on this clock
			irq_request   <= ~irq_global_mask & ((tx_buffer_empty_flag_reg & tx_empty_irq_enable) | (tc_reg & tx_complete_irq_enable));
			// one wait-free access phase: ready follows every setup cycle
			pready        <= apb_setup;
			if (apb_setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
				pslverr <= err_next;
			end else begin
				pslverr <= 1'b0;
			end
			if (wr_done) begin
				case (paddr)
					`ADDR_CTRL_ONE: begin
						ctrl_one_reg <= pwdata[`C1_W-1:0];
					end
					`ADDR_CTRL_TWO: begin
						ctrl_two_reg <= pwdata[`C2_W-1:0];
					end
					`ADDR_TX_DIV: begin
						// faster than the rated limit is clamped
						if (pwdata[`DIV_W-1:0] < DIV_MIN) begin
							tx_div_reg <= DIV_MIN;
						end else begin
							tx_div_reg <= pwdata[`DIV_W-1:0];
						end
					end
					`ADDR_RX_DIV: begin
						if (pwdata[`DIV_W-1:0] < DIV_MIN) begin
							rx_div_reg <= DIV_MIN;
						end else begin
							rx_div_reg <= pwdata[`DIV_W-1:0];
						end
					end
					default: begin
						tx_div_reg <= tx_div_reg;
					end
				endcase
			end
		end
	end

endmodule // async_serial_transmitter

// ---- design/baud_gen.v ----
`timescale 1ns/100ps
`include "serial_tx_map.vh"

module baud_gen (
	// clock and reset
	input  wire               clk_sys,
	input  wire               reset_n,
	// control
	input  wire               run,
	input  wire [`DIV_W-1:0]  divisor,
	// one pulse per bit period
	output reg                tick
);

	reg [`DIV_W-1:0] cnt_reg;

	// restarts whenever run drops, so a new frame gets a full first bit
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= {`DIV_W{1'b0}};
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= {`DIV_W{1'b0}};
			tick    <= 1'b0;
		end else if (cnt_reg == divisor - {{(`DIV_W-1){1'b0}}, 1'b1}) begin
			cnt_reg <= {`DIV_W{1'b0}};
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
			tick    <= 1'b0;
		end
	end

endmodule // baud_gen

// ---- design/serial_tx_map.vh ----
`ifndef SERIAL_TX_MAP_VH
`define SERIAL_TX_MAP_VH

// ==========================================================
// register byte addresses
`define ADDR_STATUS       8'h00
`define ADDR_DATA         8'h04
`define ADDR_CTRL_ONE     8'h08
`define ADDR_CTRL_TWO     8'h0c
`define ADDR_TX_DIV       8'h10
`define ADDR_RX_DIV       8'h14

// ==========================================================
// serial_status_reg fields
`define ST_TX_BUFFER_EMPTY_FLAG           7
`define ST_TC             6
`define ST_BUSY           1
`define ST_RX_LINE        0

// ==========================================================
// serial_control_one fields
`define C1_WORD9          0
`define C1_NINTH          1
`define C1_PAR_EN         2
`define C1_PAR_ODD        3
`define C1_W              4

// ==========================================================
// serial_control_two fields
`define C2_TX_EN          0
`define C2_RX_EN          1
`define C2_BREAK          2
`define C2_TIE            3
`define C2_TX_COMPLETE_IRQ_ENABLE           4
`define C2_W              5

// ==========================================================
// widths and reset values
`define DATA_W            8
`define WORD_W            9
`define DIV_W             16
`define CNT_W             4
`define BITS_8            4'h8
`define BITS_9            4'h9
`define FRAME_EXTRA       4'h2
`define CTRL_ONE_RST      4'h0
`define CTRL_TWO_RST      5'h00
`define DIV_RST           16'hffff
`define TX_BUFFER_EMPTY_FLAG_RST          1'b1
`define TC_RST            1'b1

// ==========================================================
// bit-rate limit
`define SYS_CLK_HZ        200000000
`define BAUD_MAX_HZ       500000
`define BAUD_DIV_MIN      ((`SYS_CLK_HZ + `BAUD_MAX_HZ - 1) / `BAUD_MAX_HZ)

`endif

// ---- design/sync_two_ff.v ----
`timescale 1ns/100ps

module sync_two_ff (
	// clock and reset
	input  wire clk_sys,
	input  wire reset_n,
	// level in and out
	input  wire din,
	output reg  dout
);

	reg meta_reg;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b1;
			dout     <= 1'b1;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule // sync_two_ff

// ---- test/serial_rx_model.sv ----
`timescale 1ns/100ps

module serial_rx_model #(
	parameter int DIV = 400
) (
	// line side
	input  wire logic       clk_sys,
	input  wire logic       serial_line,
	input  wire logic [3:0] nbits,
	// decoded frame
	output logic [8:0]      word,
	output logic            stop_bit,
	output int              count
);
	initial begin
		word = 9'h000;
		stop_bit = 1'b0;
		count = 0;
		forever begin
			@(posedge clk_sys);
			if (serial_line === 1'b0) begin
				// sample at bit centres
				repeat (DIV / 2) @(posedge clk_sys);
				word = 9'h000;
				for (int i = 0; i < nbits; i++) begin
					repeat (DIV) @(posedge clk_sys);
					word[i] = serial_line;
				end
				repeat (DIV) @(posedge clk_sys);
				stop_bit = serial_line;
				count++;
				// a break holds the line low, so wait for the mark first
				while (serial_line !== 1'b1) @(posedge clk_sys);
			end
		end
	end
endmodule // serial_rx_model

// ---- test/serial_tx_monitor.sv ----
`timescale 1ns/100ps

module serial_tx_monitor (
	// clock and reset
	input logic        clk_sys,
	input logic        reset_n,
	// apb
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// cpu side
	input logic        irq_global_mask,
	input logic        irq_request,
	// serial pins
	input logic        serial_rx_in,
	input logic        serial_tx_out,
	input logic        serial_tx_oe,
	input logic        rx_bit_tick
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// register bus
	sequence s_setup;
		psel && !penable;
	endsequence
	property p_ready_after_setup;
		s_setup |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_unmapped;
		s_setup ##0 (paddr > 8'h14) |=> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
	property p_mapped;
		s_setup ##0 (paddr <= 8'h14 && paddr[1:0] == 2'b00) |=> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped address refused");
	property p_write_reads_zero;
		pready && pwrite |-> prdata == 32'h00000000;
	endproperty
	a_write_reads_zero: assert property (p_write_reads_zero) else $error("read data on write");

	// ==========================================================
	// interrupt and serial timing
	property p_irq_masked;
		irq_global_mask |=> !irq_request;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("request while masked");
	property p_start_bit;
		$fell(serial_tx_out) |-> !serial_tx_out [*8];
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit too short");
	// the divisor floor keeps every bit at least 400 clocks
	property p_bit_hold;
		$changed(serial_tx_out) |=> $stable(serial_tx_out) [*7];
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("serial bit too short");
	property p_rx_tick;
		rx_bit_tick |=> !rx_bit_tick [*8];
	endproperty
	a_rx_tick: assert property (p_rx_tick) else $error("receive ticks too close");
endmodule // serial_tx_monitor

bind async_serial_transmitter serial_tx_monitor i_serial_tx_monitor (
	.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_global_mask(irq_global_mask),
	.irq_request(irq_request), .serial_rx_in(serial_rx_in),
	.serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe), .rx_bit_tick(rx_bit_tick)
);

// ---- test/tb_async_serial_transmitter.sv ----
`timescale 1ns/100ps
`include "serial_tx_map.vh"

module tb_async_serial_transmitter;
	localparam int DIV = 400;
	logic        clk_sys, reset_n, psel, penable, pwrite, irq_global_mask, serial_rx_in;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, slv, irq_request, serial_tx_out, serial_tx_oe, rx_bit_tick;
	logic [3:0]  nbits;
	logic [8:0]  rx_word;
	logic        rx_stop;
	int          rx_count, fails, n_compared;
	// pull-up holds the pin high once released
	wire         serial_line = serial_tx_oe ? serial_tx_out : 1'b1;

	async_serial_transmitter i_async_serial_transmitter (
		.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_global_mask(irq_global_mask),
		.irq_request(irq_request), .serial_rx_in(serial_rx_in),
		.serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe), .rx_bit_tick(rx_bit_tick)
	);
	serial_rx_model #(.DIV(DIV)) i_serial_rx_model (
		.clk_sys(clk_sys), .serial_line(serial_line), .nbits(nbits),
		.word(rx_word), .stop_bit(rx_stop), .count(rx_count)
	);

	always #2.5 clk_sys = ~clk_sys;

	// ==========================================================
	// shared tasks
	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			end_of_test;
		end
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_frame;
		int c0, n;
		c0 = rx_count;
		n = 0;
		while (rx_count == c0 && n < 36 * DIV) begin
			@(posedge clk_sys);
			n++;
		end
		if (rx_count == c0) begin
			fails++;
			end_of_test;
		end
	endtask
	task send(input logic [7:0] b);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		apb(1'b1, `ADDR_DATA, {24'h0, b});
	endtask

	// ==========================================================
	// scenarios
	task t_reset;
		chk(32'(serial_tx_oe), 32'h0);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q, 32'h000000c1);
		apb(1'b0, `ADDR_TX_DIV, 32'h0);
		chk(q, 32'h0000ffff);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(slv), 32'h1);
	endtask
	task t_first;
		int n;
		apb(1'b1, `ADDR_TX_DIV, DIV);
		apb(1'b1, `ADDR_CTRL_TWO, 32'h09);
		repeat (2) @(posedge clk_sys);
		chk(32'(serial_tx_oe), 32'h1);
		chk(32'(irq_request), 32'h1);
		irq_global_mask <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(32'(irq_request), 32'h0);
		irq_global_mask <= 1'b0;
		send(8'ha5);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		// idle frame in progress, so the byte is held
		chk({24'h0, q[7:6], 6'h0}, 32'h0);
		n = 0;
		while (serial_tx_out === 1'b1 && n < 20 * DIV) begin
			@(posedge clk_sys);
			n++;
		end
		// one whole frame of ones, no longer: the loop starts a few clocks late
		chk(32'(n >= 10 * DIV - 40 && n < 10 * DIV), 32'h1);
		wait_frame;
		chk(32'(rx_word), 32'h0a5);
		chk(32'(rx_stop), 32'h1);
		repeat (DIV) @(posedge clk_sys);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q, 32'h000000c1);
	endtask
	task t_back;
		send(8'h3c);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q, 32'h00000083);
		apb(1'b1, `ADDR_DATA, 32'hc3);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q, 32'h00000003);
		wait_frame;
		chk(32'(rx_word), 32'h03c);
		wait_frame;
		chk(32'(rx_word), 32'h0c3);
		repeat (DIV) @(posedge clk_sys);
	endtask
	task t_formats;
		apb(1'b1, `ADDR_CTRL_ONE, 32'h03);
		nbits <= 4'h9;
		send(8'h55);
		wait_frame;
		chk(32'(rx_word), 32'h155);
		repeat (DIV) @(posedge clk_sys);
		apb(1'b1, `ADDR_CTRL_ONE, 32'h04);
		nbits <= 4'h8;
		send(8'h01);
		wait_frame;
		chk(32'(rx_word), 32'h081);
		repeat (DIV) @(posedge clk_sys);
	endtask
	task t_break;
		apb(1'b1, `ADDR_CTRL_TWO, 32'h05);
		wait_frame;
		chk(32'(rx_word), 32'h000);
		chk(32'(rx_stop), 32'h0);
		repeat (DIV) @(posedge clk_sys);
		chk(32'(serial_tx_out), 32'h0);
		apb(1'b1, `ADDR_CTRL_TWO, 32'h01);
		send(8'h5a);
		wait_frame;
		chk(32'(rx_word), 32'h05a);
		chk(32'(rx_stop), 32'h1);
		repeat (DIV) @(posedge clk_sys);
	endtask
	task t_disable;
		int n, t0;
		apb(1'b1, `ADDR_RX_DIV, DIV);
		apb(1'b1, `ADDR_CTRL_TWO, 32'h02);
		repeat (4) @(posedge clk_sys);
		// receiver alone still owns the pin, idle high
		chk(32'(serial_tx_oe), 32'h1);
		chk(32'(serial_line), 32'h1);
		n = 0;
		while (rx_bit_tick !== 1'b1 && n < 2 * DIV) begin
			@(posedge clk_sys);
			n++;
		end
		t0 = n;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rx_bit_tick !== 1'b1 && n < 4 * DIV);
		chk(n - t0, DIV);
		apb(1'b1, `ADDR_CTRL_TWO, 32'h00);
		repeat (4) @(posedge clk_sys);
		chk(32'(serial_tx_oe), 32'h0);
		chk(32'(serial_line), 32'h1);
	endtask

	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_global_mask = 1'b0;
		serial_rx_in = 1'b1;
		nbits = 4'h8;
		fails = 0;
		n_compared = 0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset;
		t_first;
		t_back;
		t_formats;
		t_break;
		t_disable;
		end_of_test;
	end
endmodule // tb_async_serial_transmitter
